// File: rtl/sef_front_end.sv
// Serial memory pin front end: link shifting on the serial clock, crossings, receive buffer and write gating.
`timescale 1ns/1ps
`default_nettype none
module sef_front_end #(
    parameter int unsigned DATA_W = sef_pkg::BYTE_BITS,
    parameter int unsigned FIFO_DEPTH = sef_pkg::RX_FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic sck_in,
    input wire logic select_and_kick_n_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire logic wp_n_in,
    output logic [DATA_W-1:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic rx_overrun_out,
    input wire logic [DATA_W-1:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic write_cmd_in,
    input wire logic nv_busy_in,
    output logic nv_write_start_out,
    output logic nv_write_refused_out,
    output logic selected_out,
    output logic standby_out
);
    import sef_pkg::*;

    localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);

    initial
    begin
        if (DATA_W != BYTE_BITS || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
        begin
            $error("DATA_W must equal the byte width and FIFO_DEPTH must be a power of two, at least 2");
        end
    end

    // Core reset: asserted at once, released through two flip-flops.
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // Link domain. Select high holds the frame logic in reset, so a partial byte never survives it.
    logic [BIT_CNT_W-1:0] rx_cnt_reg;
    logic [DATA_W-2:0] rx_shift_reg;
    logic [DATA_W-1:0] rx_byte_reg;
    logic rx_tgl_reg;
    logic tx_req_meta_reg;
    logic tx_req_sync_reg;
    logic [DATA_W-1:0] tx_shift_reg;
    logic tx_active_reg;
    logic tx_ack_reg;
    logic tx_req_reg;
    logic [DATA_W-1:0] tx_hold_reg;

    always_ff @(posedge sck_in or posedge select_and_kick_n_in)
    begin
        if (select_and_kick_n_in)
        begin
            rx_cnt_reg <= BIT_CNT_ZERO;
            rx_shift_reg <= '0;
        end
        else
        begin
            rx_cnt_reg <= rx_cnt_reg + BIT_CNT_ONE;
            rx_shift_reg <= {rx_shift_reg[DATA_W-3:0], sdi_in};
        end
    end

    // The completed byte stays put for a whole byte time, which covers the core's toggle crossing.
    always_ff @(posedge sck_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            rx_byte_reg <= BYTE_ZERO;
            rx_tgl_reg <= TOGGLE_RESET;
            tx_req_meta_reg <= TOGGLE_RESET;
            tx_req_sync_reg <= TOGGLE_RESET;
        end
        else
        begin
            tx_req_meta_reg <= tx_req_reg;
            tx_req_sync_reg <= tx_req_meta_reg;
            if (!select_and_kick_n_in && rx_cnt_reg == BIT_CNT_LAST)
            begin
                rx_byte_reg <= {rx_shift_reg, sdi_in};
                rx_tgl_reg <= ~rx_tgl_reg;
            end
        end
    end

    // A new byte is loaded on the falling edge that follows each completed byte.
    always_ff @(negedge sck_in or posedge select_and_kick_n_in)
    begin
        if (select_and_kick_n_in)
        begin
            tx_shift_reg <= IDLE_FILL;
            tx_active_reg <= 1'b0;
        end
        else if (rx_cnt_reg == BIT_CNT_ZERO)
        begin
            tx_shift_reg <= (tx_req_sync_reg != tx_ack_reg) ? tx_hold_reg : IDLE_FILL;
            tx_active_reg <= tx_req_sync_reg != tx_ack_reg;
        end
        else
        begin
            tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b1};
        end
    end

    always_ff @(negedge sck_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            tx_ack_reg <= TOGGLE_RESET;
        end
        else if (!select_and_kick_n_in && rx_cnt_reg == BIT_CNT_ZERO && tx_req_sync_reg != tx_ack_reg)
        begin
            tx_ack_reg <= ~tx_ack_reg;
        end
    end

    assign sdo_out = tx_shift_reg[DATA_W-1];
    assign sdo_oe_out = tx_active_reg && !select_and_kick_n_in;

    // Core domain: two-flop synchronisers for the select and write-protect pins and for the link toggles.
    logic sel_meta_reg;
    logic sel_high_reg;
    logic sel_high_prev_reg;
    logic wp_meta_reg;
    logic wp_high_reg;
    logic rx_tgl_meta_reg;
    logic rx_tgl_sync_reg;
    logic rx_tgl_prev_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;

    always_ff @(posedge core_clk_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            sel_meta_reg <= SEL_SYNC_RESET;
            sel_high_reg <= SEL_SYNC_RESET;
            sel_high_prev_reg <= SEL_SYNC_RESET;
            wp_meta_reg <= WP_SYNC_RESET;
            wp_high_reg <= WP_SYNC_RESET;
            rx_tgl_meta_reg <= TOGGLE_RESET;
            rx_tgl_sync_reg <= TOGGLE_RESET;
            rx_tgl_prev_reg <= TOGGLE_RESET;
            ack_meta_reg <= TOGGLE_RESET;
            ack_sync_reg <= TOGGLE_RESET;
        end
        else
        begin
            sel_meta_reg <= select_and_kick_n_in;
            sel_high_reg <= sel_meta_reg;
            sel_high_prev_reg <= sel_high_reg;
            wp_meta_reg <= wp_n_in;
            wp_high_reg <= wp_meta_reg;
            rx_tgl_meta_reg <= rx_tgl_reg;
            rx_tgl_sync_reg <= rx_tgl_meta_reg;
            rx_tgl_prev_reg <= rx_tgl_sync_reg;
            ack_meta_reg <= tx_ack_reg;
            ack_sync_reg <= ack_meta_reg;
        end
    end

    logic sel_fall;
    logic sel_rise;
    logic rx_byte_seen;
    assign sel_fall = sel_high_prev_reg && !sel_high_reg;
    assign sel_rise = !sel_high_prev_reg && sel_high_reg;
    assign rx_byte_seen = rx_tgl_sync_reg != rx_tgl_prev_reg;

    // The select synchroniser resets low, so a select already low at power-up shows no fall.
    logic frame_ok_reg;

    always_ff @(posedge core_clk_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            frame_ok_reg <= 1'b0;
        end
        else if (sel_fall)
        begin
            frame_ok_reg <= 1'b1;
        end
        else if (sel_high_reg)
        begin
            frame_ok_reg <= 1'b0;
        end
    end

    assign selected_out = frame_ok_reg;
    assign standby_out = sel_high_reg && !nv_busy_in;

    // Receive buffer. The link cannot be stalled, so a push into a full buffer is counted as an overrun.
    logic [DATA_W-1:0] fifo_mem_reg [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] fill_reg;
    logic fifo_full;
    logic fifo_empty;
    logic push_valid;
    logic push_ready;
    logic push;
    logic pop;

    assign fifo_full = fill_reg == CNT_W'(FIFO_DEPTH);
    assign fifo_empty = fill_reg == '0;
    assign push_valid = rx_byte_seen && frame_ok_reg;
    assign push_ready = !fifo_full;
    assign push = push_valid && push_ready;
    assign pop = rx_ready_in && !fifo_empty;
    assign rx_valid_out = !fifo_empty;
    assign rx_data_out = fifo_mem_reg[rd_ptr_reg];

    always_ff @(posedge core_clk_in)
    begin
        if (push)
        begin
            fifo_mem_reg[wr_ptr_reg] <= rx_byte_reg;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
            end
            if (push && !pop)
            begin
                fill_reg <= fill_reg + CNT_W'(1);
            end
            else if (pop && !push)
            begin
                fill_reg <= fill_reg - CNT_W'(1);
            end
        end
    end

    // Overrun is sticky within a frame; a new overrun in the clearing cycle still sets it.
    always_ff @(posedge core_clk_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            rx_overrun_out <= 1'b0;
        end
        else if (push_valid && !push_ready)
        begin
            rx_overrun_out <= 1'b1;
        end
        else if (sel_fall)
        begin
            rx_overrun_out <= 1'b0;
        end
    end

    // Transmit holding register. Its contents stay still from the request toggle until the link acknowledges.
    assign tx_ready_out = frame_ok_reg && (tx_req_reg == ack_sync_reg);

    always_ff @(posedge core_clk_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            tx_hold_reg <= IDLE_FILL;
            tx_req_reg <= TOGGLE_RESET;
        end
        else if (tx_valid_in && tx_ready_out)
        begin
            tx_hold_reg <= tx_data_in;
            tx_req_reg <= ~tx_req_reg;
        end
    end

    // Write gating. The start pulse is the commit point; nothing watches write-protect after it.
    sef_nv_state_t nv_state_reg;
    sef_nv_state_t nv_state_next;
    logic start_next;
    logic refuse_next;

    always_comb
    begin
        nv_state_next = nv_state_reg;
        start_next = 1'b0;
        refuse_next = 1'b0;
        unique case (nv_state_reg)
            NV_IDLE:
            begin
                if (frame_ok_reg && write_cmd_in)
                begin
                    nv_state_next = wp_high_reg ? NV_ARMED : NV_ABORTED;
                end
            end
            NV_ARMED:
            begin
                if (!wp_high_reg)
                begin
                    nv_state_next = NV_ABORTED;
                end
                else if (sel_rise)
                begin
                    nv_state_next = NV_IDLE;
                    start_next = 1'b1;
                end
            end
            NV_ABORTED:
            begin
                if (sel_rise)
                begin
                    nv_state_next = NV_IDLE;
                    refuse_next = 1'b1;
                end
            end
            default:
            begin
                nv_state_next = NV_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            nv_state_reg <= NV_IDLE;
            nv_write_start_out <= 1'b0;
            nv_write_refused_out <= 1'b0;
        end
        else
        begin
            nv_state_reg <= nv_state_next;
            nv_write_start_out <= start_next;
            nv_write_refused_out <= refuse_next;
        end
    end
endmodule : sef_front_end
`default_nettype wire

// File: shared/sef_pkg.sv
// Constants, field positions and state codes for the serial memory pin front end.
// Function
// - The serial output changes only after a falling edge of the serial clock while read data is shifted out.
// - The serial input is sampled on every rising edge of the serial clock.
// - While select is high the device is deselected and its serial output is not driven.
// - When deselected the device enters standby only once no nonvolatile write cycle is running.
// - Select low enables the device and makes it active, ready for serial transfers.
// - After power-up nothing is acted on until a high-to-low select transition has been seen.
// - While write-protect is low every nonvolatile write is refused and all else works normally.
// - While write-protect is high every function, nonvolatile writes included, works without restriction.
// - Write-protect falling while select is low during a write command aborts that write.
// - Once a nonvolatile write cycle has begun a fall of write-protect does not disturb it.
// - Every byte travels most significant bit first in both directions.
package sef_pkg;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 3'h0;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 3'h1;
    localparam logic [BYTE_BITS-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_BITS-1:0] IDLE_FILL = 8'hFF;
    localparam int unsigned RX_FIFO_DEPTH = 2;
    localparam logic SEL_SYNC_RESET = 1'b0;
    localparam logic WP_SYNC_RESET = 1'b0;
    localparam logic TOGGLE_RESET = 1'b0;
    localparam int unsigned CORE_CLK_HZ = 25000000;

    typedef enum logic [1:0]
    {
        NV_IDLE = 2'b00,
        NV_ARMED = 2'b01,
        NV_ABORTED = 2'b10
    } sef_nv_state_t;
endpackage : sef_pkg

// File: sim/sef_front_end_props.sv
// Port checker for the serial memory pin front end.
`timescale 1ns/1ps
`default_nettype none
module sef_front_end_props #(
    parameter int unsigned DATA_W = 8
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic sck_in,
    input wire logic select_and_kick_n_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic wp_n_in,
    input wire logic [DATA_W-1:0] rx_data_out,
    input wire logic rx_valid_out,
    input wire logic rx_ready_in,
    input wire logic tx_ready_out,
    input wire logic nv_busy_in,
    input wire logic nv_write_start_out,
    input wire logic nv_write_refused_out,
    input wire logic selected_out,
    input wire logic standby_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    oe_deselect_a: assert property (select_and_kick_n_in |-> !sdo_oe_out)
        else $error("Serial output driven while deselected.");
    sdo_hold_a: assert property (disable iff (!arst_n_in || select_and_kick_n_in)
        sck_in && $past(sck_in) |-> $stable(sdo_out)) else $error("Serial output moved while clock high.");
    busy_awake_a: assert property (nv_busy_in |-> !standby_out)
        else $error("Standby during a write cycle.");
    standby_on_a: assert property (select_and_kick_n_in [*8] ##0 !nv_busy_in |-> standby_out)
        else $error("No standby while idle and deselected.");
    quiet_idle_a: assert property (select_and_kick_n_in [*8] |-> !selected_out)
        else $error("Selected while select is high.");
    select_wakes_a: assert property (select_and_kick_n_in [*8] ##1 !select_and_kick_n_in [*6] |-> selected_out)
        else $error("Select fall did not activate.");
    ready_gate_a: assert property (!selected_out |-> !tx_ready_out)
        else $error("Read data taken while not selected.");
    start_wp_a: assert property (nv_write_start_out |-> $past(wp_n_in, 6) && !nv_write_refused_out)
        else $error("Write started under protection.");
    start_kept_a: assert property (nv_write_start_out |=> (!nv_write_start_out && !nv_write_refused_out) [*8])
        else $error("Started write disturbed.");
    refuse_once_a: assert property (nv_write_refused_out |=> !nv_write_refused_out)
        else $error("Refusal pulse too long.");
    rx_held_a: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
        else $error("Stalled byte lost.");
endmodule : sef_front_end_props
bind sef_front_end sef_front_end_props #(.DATA_W(DATA_W)) u_props (.core_clk_in, .arst_n_in, .sck_in,
    .select_and_kick_n_in, .sdo_out, .sdo_oe_out, .wp_n_in, .rx_data_out, .rx_valid_out, .rx_ready_in,
    .tx_ready_out, .nv_busy_in, .nv_write_start_out, .nv_write_refused_out, .selected_out, .standby_out);
`default_nettype wire

// File: sim/sef_front_end_tb.sv
// Self-checking bench for the serial memory pin front end.
`timescale 1ns/1ps
`default_nettype none
module sef_front_end_tb;
    logic core_clk;
    logic arst_n;
    logic wp_n;
    logic rx_ready;
    logic tx_valid;
    logic write_cmd;
    logic nv_busy;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [7:0] q;
    wire sck;
    wire sel_n;
    wire sdi;
    logic sdo;
    logic sdo_oe;
    logic rx_valid;
    logic overrun;
    logic tx_ready;
    logic wr_start;
    logic wr_ref;
    logic selected;
    logic standby;
    logic [7:0] n_start = 8'h00;
    logic [7:0] n_ref = 8'h00;
    int errors = 0;
    int n_compared = 0;
    sef_front_end DUT (.core_clk_in(core_clk), .arst_n_in(arst_n), .sck_in(sck), .select_and_kick_n_in(sel_n),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .wp_n_in(wp_n), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_overrun_out(overrun), .tx_data_in(tx_data),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .write_cmd_in(write_cmd), .nv_busy_in(nv_busy),
        .nv_write_start_out(wr_start), .nv_write_refused_out(wr_ref), .selected_out(selected),
        .standby_out(standby));
    sef_host_model host (.sck_out(sck), .sel_n_out(sel_n), .sdi_out(sdi), .sdo_in(sdo), .sdo_oe_in(sdo_oe));
    always @(posedge core_clk) if (wr_start === 1'b1) n_start <= n_start + 8'h01;
    always @(posedge core_clk) if (wr_ref === 1'b1) n_ref <= n_ref + 8'h01;
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic chk1(input string what, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask : chk1
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk8
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    task automatic pop(input logic [7:0] e);
        #1;
        chk1("rx_valid", 1'b1, rx_valid);
        chk8("rx_data", e, rx_data);
        @(posedge core_clk);
        rx_ready <= 1'b1;
        @(posedge core_clk);
        rx_ready <= 1'b0;
    endtask : pop
    task automatic t_powerup;
        host.xbits(8, 8'hC5, q);
        cyc(6);
        #1;
        chk1("rx_valid", 1'b0, rx_valid);
        chk1("selected", 1'b0, selected);
        host.sel(1'b1);
    endtask : t_powerup
    task automatic t_rx;
        host.sel(1'b0);
        host.xbits(8, 8'hC5, q);
        host.xbits(8, 8'h36, q);
        host.xbits(8, 8'h5A, q);
        cyc(5);
        #1;
        chk1("overrun", 1'b1, overrun);
        pop(8'hC5);
        pop(8'h36);
        #1;
        chk1("rx_valid", 1'b0, rx_valid);
        host.sel(1'b1);
    endtask : t_rx
    task automatic t_partial;
        host.sel(1'b0);
        host.xbits(4, 8'hF0, q);
        host.sel(1'b1);
        host.sel(1'b0);
        host.xbits(8, 8'h81, q);
        cyc(5);
        pop(8'h81);
        chk1("overrun", 1'b0, overrun);
        #1;
        chk1("rx_valid", 1'b0, rx_valid);
        host.sel(1'b1);
    endtask : t_partial
    task automatic t_tx;
        host.sel(1'b0);
        #1;
        chk1("sdo_oe", 1'b0, sdo_oe);
        @(posedge core_clk);
        tx_data <= 8'hB2;
        tx_valid <= 1'b1;
        for (int i = 0; i < 20 && tx_ready !== 1'b1; i++) @(negedge core_clk);
        chk1("tx_ready", 1'b1, tx_ready);
        @(posedge core_clk);
        tx_valid <= 1'b0;
        host.xbits(8, 8'h00, q);
        host.xbits(8, 8'h00, q);
        chk8("sdo_byte", 8'hB2, q);
        #1;
        chk1("sdo_oe", 1'b0, sdo_oe);
        host.sel(1'b1);
        chk1("tx_ready", 1'b0, tx_ready);
        pop(8'h00);
        pop(8'h00);
    endtask : t_tx
    task automatic t_write(input logic ws, input logic wd, input logic [7:0] es, input logic [7:0] er);
        logic [7:0] s0;
        logic [7:0] r0;
        s0 = n_start;
        r0 = n_ref;
        @(posedge core_clk);
        wp_n <= ws;
        write_cmd <= 1'b1;
        host.sel(1'b0);
        host.xbits(8, 8'h02, q);
        if (wd)
        begin
            @(posedge core_clk);
            wp_n <= 1'b0;
        end
        host.xbits(8, 8'h40, q);
        host.sel(1'b1);
        @(posedge core_clk);
        write_cmd <= 1'b0;
        cyc(8);
        chk8("starts", es, n_start - s0);
        chk8("refusals", er, n_ref - r0);
        pop(8'h02);
        pop(8'h40);
        wp_n <= 1'b1;
    endtask : t_write
    task automatic t_busy;
        logic [7:0] r0;
        r0 = n_ref;
        @(posedge core_clk);
        nv_busy <= 1'b1;
        wp_n <= 1'b0;
        cyc(4);
        #1;
        chk1("standby", 1'b0, standby);
        chk8("refusals", 8'h00, n_ref - r0);
        @(posedge core_clk);
        nv_busy <= 1'b0;
        wp_n <= 1'b1;
        cyc(2);
        #1;
        chk1("standby", 1'b1, standby);
    endtask : t_busy
    initial
    begin
        arst_n = 1'b0;
        wp_n = 1'b1;
        rx_ready = 1'b0;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        write_cmd = 1'b0;
        nv_busy = 1'b0;
        cyc(5);
        arst_n <= 1'b1;
        cyc(4);
        t_powerup();
        t_rx();
        t_partial();
        t_tx();
        t_write(1'b1, 1'b0, 8'h01, 8'h00);
        t_busy();
        t_write(1'b0, 1'b0, 8'h00, 8'h01);
        t_write(1'b1, 1'b1, 8'h00, 8'h01);
        wrap_up();
    end
    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule : sef_front_end_tb
`default_nettype wire

// File: sim/sef_host_model.sv
// Behavioural host controller on the serial link, mode 0, clock still between frames.
`timescale 1ns/1ps
`default_nettype none
module sef_host_model (
    output logic sck_out,
    output logic sel_n_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in
);
    logic last;
    // An undriven output has no pull, so it shows the inverse of its last level.
    wire line = sdo_oe_in ? sdo_in : ~last;
    initial
    begin
        sck_out = 1'b0;
        sel_n_out = 1'b0;
        sdi_out = 1'b0;
        last = 1'b0;
    end
    task automatic sel(input logic v);
        #407;
        sel_n_out = v;
        #407;
    endtask : sel
    task automatic xbits(input int n, input logic [7:0] d, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            sdi_out = d[i];
            #62.5;
            sck_out = 1'b1;
            q = {q[6:0], line};
            last = line;
            #62.5;
            sck_out = 1'b0;
        end
        sdi_out = ~sdi_out;
    endtask : xbits
endmodule : sef_host_model
`default_nettype wire
